// ### hw/can_int_defines.vh
// Register offsets, field positions, reset values and mode codes for the CAN interrupt gate
`ifndef CAN_INT_DEFINES_VH
`define CAN_INT_DEFINES_VH

// ==========================================================
// Register map (byte offsets on the plain register port)
`define OFS_CAN_INT_ENABLE    4'h0
`define OFS_CAN_INT_PRIORITY  4'h1
`define OFS_CAN_INT_FLAGS     4'h2
`define OFS_TX_BUFFER_INT_EN  4'h3
`define OFS_BUFFER_INT_EN     4'h4
`define OFS_CAN_CONTROL       4'h5
`define OFS_CAN_STATUS        4'h6
`define OFS_FUNC_MODE         4'h7

// ==========================================================
// Bit positions of the enable, priority and flag bytes
`define BIT_INVALID_MSG       7
`define BIT_WAKEUP            6
`define BIT_MODULE_ERROR      5
`define BIT_TX_MASTER         4
`define BIT_TX1               3
`define BIT_TX0               2
`define BIT_RX_MASTER         1
`define BIT_WATERMARK         0

// ==========================================================
// Reset values and masks
`define RST_BYTE              8'h00
`define TX_BUF_EN_MASK        8'h1C
`define ENH_FORCE_MASK        8'hF3
`define MODE1_BIT0_MASK       8'hFE
`define MODE_REQ_MSB          7
`define MODE_REQ_LSB          5

// ==========================================================
// Operating mode codes (three-bit request and status)
`define MODE_STATUS_NORMAL         3'h0
`define MODE_STATUS_SLEEP          3'h1
`define MODE_STATUS_LOOPBACK       3'h2
`define MODE_STATUS_LISTEN         3'h3
`define MODE_STATUS_CONFIG         3'h4

// Functional modes
`define FMODE_0               2'h0
`define FMODE_1               2'h1
`define FMODE_2               2'h2

`endif

// ### hw/can_int_gate.v
// CAN interrupt enable, priority gating and operating-mode handshake
//
// Local design decisions: the placing of the registers and the strobed register port.

`default_nettype none
`include "can_int_defines.vh"

module can_int_gate #(
   parameter NUM_PROG_BUF = 6                // Programmable buffers
) (
   input  wire                    i_clk,           // System clock, 250 MHz
   input  wire                    i_srst,          // Synchronous reset, active high
   input  wire [3:0]              i_addr,          // Register address
   input  wire [7:0]              i_wdata,         // Write data
   input  wire                    i_wr,            // Write strobe
   input  wire                    i_rd,            // Read strobe
   output reg  [7:0]              o_rdata,         // Read data, cycle after strobe
   input  wire                    i_invalid_msg,   // Invalid message event pulse
   input  wire                    i_wakeup,        // Bus activity event pulse
   input  wire                    i_module_error,  // Module error event pulse
   input  wire [2:0]              i_tx_done,       // Transmit buffer 2..0 done pulses
   input  wire [1:0]              i_rx_done,       // Receive buffer 1..0 received pulses
   input  wire [NUM_PROG_BUF-1:0] i_prog_done,     // Programmable buffer event pulses
   input  wire [NUM_PROG_BUF-1:0] i_prog_is_tx,    // Programmable buffer is transmit
   input  wire                    i_watermark,     // FIFO high watermark level
   input  wire                    i_tx_pending,    // Any transmission still pending
   output wire                    o_irq_high,      // High-priority interrupt request
   output wire                    o_irq_low,       // Low-priority interrupt request
   output wire [2:0]              o_mode_status,   // Operating mode entered
   output wire [1:0]              o_func_mode      // Functional mode
);

   // ==========================================================
   // Registers
   reg  [7:0]              can_int_enable;
   reg  [7:0]              can_int_priority;
   wire [7:0]              can_int_flags;
   reg  [7:0]              tx_buffer_int_enable;
   reg  [7:0]              buffer_int_enable;
   reg  [2:0]              mode_request;
   reg  [2:0]              mode_status;
   reg  [1:0]              func_mode;
   reg                     high_q;
   reg                     low_q;

   wire                    enhanced   = (func_mode == `FMODE_1) || (func_mode == `FMODE_2);
   wire                    mode2      = (func_mode == `FMODE_2);
   wire                    mode1      = (func_mode == `FMODE_1);

   // Mask applied to enable, priority and flag bytes by functional mode
   wire [7:0]              byte_mask  = !enhanced ? 8'hFF :
                                        (mode1 ? (`ENH_FORCE_MASK & `MODE1_BIT0_MASK)
                                               : `ENH_FORCE_MASK);

   wire [7:0]              en_eff     = can_int_enable & byte_mask;
   wire [7:0]              pr_eff     = can_int_priority & byte_mask;

   // ==========================================================
   // Per-buffer sources in Modes 1 and 2
   wire                    tx_master  = en_eff[`BIT_TX_MASTER];
   wire                    rx_master  = en_eff[`BIT_RX_MASTER];
   wire [NUM_PROG_BUF-1:0] prog_en    = buffer_int_enable[7:2];

   // Individual buffer events that survive the per-buffer enables
   wire                    tx_any_ev  = enhanced & tx_master &
                                        ((|(i_tx_done & tx_buffer_int_enable[4:2])) |
                                         (|(i_prog_done & i_prog_is_tx & prog_en)));
   wire                    rx_any_ev  = enhanced & rx_master &
                                        ((|(i_rx_done & buffer_int_enable[1:0])) |
                                         (|(i_prog_done & ~i_prog_is_tx & prog_en)));

   // ==========================================================
   // Flag byte: event sets win over software clear
   reg  [7:0]              set_vec;
   always @* begin
      set_vec = 8'h00;
      set_vec[`BIT_INVALID_MSG]  = i_invalid_msg;
      set_vec[`BIT_WAKEUP]       = i_wakeup;
      set_vec[`BIT_MODULE_ERROR] = i_module_error;
      if (enhanced) begin
         set_vec[`BIT_TX_MASTER] = tx_any_ev;
         set_vec[`BIT_RX_MASTER] = rx_any_ev;
         set_vec[`BIT_WATERMARK] = mode2 & i_watermark;
      end else begin
         set_vec[`BIT_TX_MASTER] = i_tx_done[2];
         set_vec[`BIT_TX1]       = i_tx_done[1];
         set_vec[`BIT_TX0]       = i_tx_done[0];
         set_vec[`BIT_RX_MASTER] = i_rx_done[1];
         set_vec[`BIT_WATERMARK] = i_rx_done[0];
      end
   end

   // ==========================================================
   // Per-source cells: sticky flag, enable gate, priority steering
   // Software write replaces the flag byte; same-cycle events still set
   wire                    flag_wr    = i_wr && (i_addr == `OFS_CAN_INT_FLAGS);
   wire [7:0]              high_vec;
   wire [7:0]              low_vec;

   // Bit 7: invalid message received
   can_irq_cell cell_invalid_msg (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .i_keep (byte_mask[`BIT_INVALID_MSG]),
      .i_set  (set_vec[`BIT_INVALID_MSG]),
      .i_wr   (flag_wr),
      .i_wbit (i_wdata[`BIT_INVALID_MSG]),
      .i_en   (en_eff[`BIT_INVALID_MSG]),
      .i_prio (pr_eff[`BIT_INVALID_MSG]),
      .o_flag (can_int_flags[`BIT_INVALID_MSG]),
      .o_high (high_vec[`BIT_INVALID_MSG]),
      .o_low  (low_vec[`BIT_INVALID_MSG])
   );

   // Bit 6: bus-activity wake-up
   can_irq_cell cell_wakeup (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .i_keep (byte_mask[`BIT_WAKEUP]),
      .i_set  (set_vec[`BIT_WAKEUP]),
      .i_wr   (flag_wr),
      .i_wbit (i_wdata[`BIT_WAKEUP]),
      .i_en   (en_eff[`BIT_WAKEUP]),
      .i_prio (pr_eff[`BIT_WAKEUP]),
      .o_flag (can_int_flags[`BIT_WAKEUP]),
      .o_high (high_vec[`BIT_WAKEUP]),
      .o_low  (low_vec[`BIT_WAKEUP])
   );

   // Bit 5: combined module error
   can_irq_cell cell_module_error (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .i_keep (byte_mask[`BIT_MODULE_ERROR]),
      .i_set  (set_vec[`BIT_MODULE_ERROR]),
      .i_wr   (flag_wr),
      .i_wbit (i_wdata[`BIT_MODULE_ERROR]),
      .i_en   (en_eff[`BIT_MODULE_ERROR]),
      .i_prio (pr_eff[`BIT_MODULE_ERROR]),
      .o_flag (can_int_flags[`BIT_MODULE_ERROR]),
      .o_high (high_vec[`BIT_MODULE_ERROR]),
      .o_low  (low_vec[`BIT_MODULE_ERROR])
   );

   // ==========================================================
   // Mode-dependent sources: meaning follows the functional mode

   // Bit 4: transmit buffer 2, or any transmit buffer in Modes 1/2
   can_irq_cell cell_tx_master (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .i_keep (byte_mask[`BIT_TX_MASTER]),
      .i_set  (set_vec[`BIT_TX_MASTER]),
      .i_wr   (flag_wr),
      .i_wbit (i_wdata[`BIT_TX_MASTER]),
      .i_en   (en_eff[`BIT_TX_MASTER]),
      .i_prio (pr_eff[`BIT_TX_MASTER]),
      .o_flag (can_int_flags[`BIT_TX_MASTER]),
      .o_high (high_vec[`BIT_TX_MASTER]),
      .o_low  (low_vec[`BIT_TX_MASTER])
   );

   // Bit 3: transmit buffer 1, Mode 0 only
   can_irq_cell cell_tx1 (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .i_keep (byte_mask[`BIT_TX1]),
      .i_set  (set_vec[`BIT_TX1]),
      .i_wr   (flag_wr),
      .i_wbit (i_wdata[`BIT_TX1]),
      .i_en   (en_eff[`BIT_TX1]),
      .i_prio (pr_eff[`BIT_TX1]),
      .o_flag (can_int_flags[`BIT_TX1]),
      .o_high (high_vec[`BIT_TX1]),
      .o_low  (low_vec[`BIT_TX1])
   );

   // Bit 2: transmit buffer 0, Mode 0 only
   can_irq_cell cell_tx0 (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .i_keep (byte_mask[`BIT_TX0]),
      .i_set  (set_vec[`BIT_TX0]),
      .i_wr   (flag_wr),
      .i_wbit (i_wdata[`BIT_TX0]),
      .i_en   (en_eff[`BIT_TX0]),
      .i_prio (pr_eff[`BIT_TX0]),
      .o_flag (can_int_flags[`BIT_TX0]),
      .o_high (high_vec[`BIT_TX0]),
      .o_low  (low_vec[`BIT_TX0])
   );

   // Bit 1: receive buffer 1, or any receive buffer in Modes 1/2
   can_irq_cell cell_rx_master (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .i_keep (byte_mask[`BIT_RX_MASTER]),
      .i_set  (set_vec[`BIT_RX_MASTER]),
      .i_wr   (flag_wr),
      .i_wbit (i_wdata[`BIT_RX_MASTER]),
      .i_en   (en_eff[`BIT_RX_MASTER]),
      .i_prio (pr_eff[`BIT_RX_MASTER]),
      .o_flag (can_int_flags[`BIT_RX_MASTER]),
      .o_high (high_vec[`BIT_RX_MASTER]),
      .o_low  (low_vec[`BIT_RX_MASTER])
   );

   // Bit 0: receive buffer 0, absent in Mode 1, watermark in Mode 2
   can_irq_cell cell_watermark (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .i_keep (byte_mask[`BIT_WATERMARK]),
      .i_set  (set_vec[`BIT_WATERMARK]),
      .i_wr   (flag_wr),
      .i_wbit (i_wdata[`BIT_WATERMARK]),
      .i_en   (en_eff[`BIT_WATERMARK]),
      .i_prio (pr_eff[`BIT_WATERMARK]),
      .o_flag (can_int_flags[`BIT_WATERMARK]),
      .o_high (high_vec[`BIT_WATERMARK]),
      .o_low  (low_vec[`BIT_WATERMARK])
   );

   // ==========================================================
   // Software-written registers
   always @(posedge i_clk) begin
      if (i_srst) begin
         can_int_enable       <= `RST_BYTE;
         can_int_priority     <= `RST_BYTE;
         tx_buffer_int_enable <= `RST_BYTE;
         buffer_int_enable    <= `RST_BYTE;
         mode_request         <= `MODE_STATUS_CONFIG;
         func_mode            <= `FMODE_0;
      end else if (i_wr) begin
         case (i_addr)
            `OFS_CAN_INT_ENABLE:   can_int_enable   <= i_wdata & byte_mask;
            `OFS_CAN_INT_PRIORITY: can_int_priority <= i_wdata & byte_mask;
            `OFS_TX_BUFFER_INT_EN: if (enhanced) begin
               tx_buffer_int_enable <= i_wdata & `TX_BUF_EN_MASK;
            end
            `OFS_BUFFER_INT_EN:    if (enhanced) begin
               buffer_int_enable <= i_wdata;
            end
            `OFS_CAN_CONTROL:      mode_request <= i_wdata[`MODE_REQ_MSB:`MODE_REQ_LSB];
            `OFS_FUNC_MODE:        if (mode_status == `MODE_STATUS_CONFIG) begin
               func_mode <= (i_wdata[1:0] == 2'h3) ? `FMODE_0 : i_wdata[1:0];
            end
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Mode handshake: status follows request once transmissions drain
   reg [2:0] next_mode_status;
   always @* begin
      next_mode_status = mode_status;
      if (mode_request != mode_status && !i_tx_pending) begin
         next_mode_status = mode_request;
      end
   end

   always @(posedge i_clk) begin
      if (i_srst) begin
         mode_status <= `MODE_STATUS_CONFIG;
      end else begin
         mode_status <= next_mode_status;
      end
   end

   // ==========================================================
   // Interrupt routing
   always @(posedge i_clk) begin
      if (i_srst) begin
         high_q <= 1'b0;
         low_q  <= 1'b0;
      end else begin
         high_q <= |high_vec;
         low_q  <= |low_vec;
      end
   end

   // Registered outputs keep the core's request inputs glitch-free
   assign o_irq_high    = high_q;
   assign o_irq_low     = low_q;
   assign o_mode_status = mode_status;
   assign o_func_mode   = func_mode;

   // ==========================================================
   // Read port
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            `OFS_CAN_INT_ENABLE:   o_rdata <= en_eff;
            `OFS_CAN_INT_PRIORITY: o_rdata <= pr_eff;
            `OFS_CAN_INT_FLAGS:    o_rdata <= can_int_flags;
            `OFS_TX_BUFFER_INT_EN: o_rdata <= enhanced ? tx_buffer_int_enable : 8'h00;
            `OFS_BUFFER_INT_EN:    o_rdata <= enhanced ? buffer_int_enable : 8'h00;
            `OFS_CAN_CONTROL:      o_rdata <= {mode_request, 5'h00};
            `OFS_CAN_STATUS:       o_rdata <= {mode_status, 5'h00};
            `OFS_FUNC_MODE:        o_rdata <= {6'h00, func_mode};
            default:               o_rdata <= 8'h00;
         endcase
      end else begin
         o_rdata <= 8'h00;
      end
   end

endmodule // can_int_gate

// ==========================================================
// One interrupt source: sticky flag, enable gate and priority steering
module can_irq_cell #(
   parameter [0:0] RST_FLAG = 1'b0    // Flag value after reset
) (
   input  wire i_clk,                 // System clock
   input  wire i_srst,                // Synchronous reset, active high
   input  wire i_keep,                // Bit exists in the current functional mode
   input  wire i_set,                 // Event sets the flag this cycle
   input  wire i_wr,                  // Software writes the flag byte
   input  wire i_wbit,                // Value written by software
   input  wire i_en,                  // Effective enable bit
   input  wire i_prio,                // Priority bit, 1 steers to the high request
   output reg  o_flag,                // Sticky flag
   output wire o_high,                // Gated request, high side
   output wire o_low                  // Gated request, low side
);

   // A zero enable keeps the flag but silences its request
   wire        req = o_flag & i_en;

   // A set wins over a same-cycle software clear, so no event is lost
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_flag <= RST_FLAG;
      end else if (!i_keep) begin
         // Bit absent in this functional mode is cleared and reads zero
         o_flag <= 1'b0;
      end else if (i_wr) begin
         o_flag <= i_wbit | i_set;
      end else begin
         o_flag <= o_flag | i_set;
      end
   end

   // ==========================================================
   // Steering
   assign o_high = req & i_prio;
   assign o_low  = req & ~i_prio;

endmodule // can_irq_cell

`default_nettype wire

// ### tb/can_int_gate_monitor.sv
// Port-level assertion checker for the CAN interrupt gate
`default_nettype none
module can_int_gate_monitor (
   input wire logic       i_clk,         // Clock
   input wire logic       i_srst,        // Reset
   input wire logic [3:0] i_addr,        // Address
   input wire logic [7:0] i_wdata,       // Write data
   input wire logic       i_wr,          // Write strobe
   input wire logic       i_rd,          // Read strobe
   input wire logic       i_tx_pending,  // Pending send
   input wire logic [7:0] o_rdata,       // Read data
   input wire logic       o_irq_high,    // High request
   input wire logic       o_irq_low,     // Low request
   input wire logic [2:0] o_mode_status, // Mode entered
   input wire logic [1:0] o_func_mode    // Functional mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // ========
   // Properties
   property p_quiet; $past(i_srst) |-> (!o_irq_high && !o_irq_low) [*2]; endproperty
   a_quiet: assert property (p_quiet) else $error("irq after reset");
   property p_hold; i_tx_pending |=> $stable(o_mode_status); endproperty
   a_hold: assert property (p_hold) else $error("mode moved while pending");
   property p_ack;
      i_wr && i_addr == 4'h5 && !i_tx_pending ##1 !i_tx_pending
      |=> {o_mode_status, 5'h00} == ($past(i_wdata, 2) & 8'hE0);
   endproperty
   a_ack: assert property (p_ack) else $error("mode status wrong");
   property p_tx_spare; i_rd && i_addr == 4'h3 |=> (o_rdata & 8'hE3) == 8'h00; endproperty
   a_tx_spare: assert property (p_tx_spare) else $error("tx enable spare bits");
   property p_force; i_rd && i_addr < 4'h3 && o_func_mode != 2'h0 |=> o_rdata[3:2] == 2'h0;
   endproperty
   a_force: assert property (p_force) else $error("bits 3:2 not forced");
   property p_bit0; i_rd && i_addr < 4'h3 && o_func_mode == 2'h1 |=> !o_rdata[0]; endproperty
   a_bit0: assert property (p_bit0) else $error("bit 0 in mode 1");
   property p_m0; i_rd && o_func_mode == 2'h0 && i_addr inside {4'h3, 4'h4} |=> o_rdata == 0;
   endproperty
   a_m0: assert property (p_m0) else $error("buffer reg in mode 0");
   property p_fm; !(i_wr && i_addr == 4'h7) |=> $stable(o_func_mode); endproperty
   a_fm: assert property (p_fm) else $error("func mode moved");
   c_high: cover property (o_irq_high);
   c_low: cover property (o_irq_low && !o_irq_high);
   c_mode: cover property (o_mode_status == 3'h1);
endmodule // can_int_gate_monitor
bind can_int_gate can_int_gate_monitor i_can_int_gate_monitor (.i_clk, .i_srst, .i_addr,
   .i_wdata, .i_wr, .i_rd, .i_tx_pending, .o_rdata, .o_irq_high, .o_irq_low, .o_mode_status,
   .o_func_mode);
`default_nettype wire

// ### tb/cpu_irq_model.sv
// Processor-side model taking the two interrupt request levels
`default_nettype none
module cpu_irq_model (
   input  wire logic       i_clk,      // Clock
   input  wire logic       i_irq_high, // High request
   input  wire logic       i_irq_low,  // Low request
   output var  logic [1:0] o_taken     // 2 high, 1 low, 0 none
);
   timeunit 1ns;
   timeprecision 1ps;
   // High preempts low, so a low source is starved while high stands
   always_ff @(posedge i_clk) o_taken <= i_irq_high ? 2'h2 : {1'b0, i_irq_low};
endmodule // cpu_irq_model
`default_nettype wire

// ### tb/tb_can_int_gate.sv
// Self-checking bench for the CAN interrupt gate
`default_nettype none
`include "can_int_defines.vh"
module tb_can_int_gate;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, srst, wr, rd, wm, pend, hi, lo;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, e, p, f;
   logic [2:0] ev, txd, ms;
   logic [1:0] rxd, fm, taken, k;
   logic [5:0] pd, ptx;
   integer     seed, n_mismatch, compares, i, m;
   can_int_gate i_can_int_gate (.i_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_invalid_msg(ev[2]), .i_wakeup(ev[1]),
      .i_module_error(ev[0]), .i_tx_done(txd), .i_rx_done(rxd), .i_prog_done(pd),
      .i_prog_is_tx(ptx), .i_watermark(wm), .i_tx_pending(pend), .o_irq_high(hi),
      .o_irq_low(lo), .o_mode_status(ms), .o_func_mode(fm));
   cpu_irq_model i_cpu_irq_model (.i_clk(clk), .i_irq_high(hi), .i_irq_low(lo), .o_taken(taken));
   // ========
   // Helpers
   function automatic logic [7:0] mask(input logic [1:0] md);
      return md == 2'h0 ? 8'hFF : (md == 2'h1 ? 8'hF2 : 8'hF3);
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] x);
      compares++;
      if (got !== x) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, x);
      end
   endtask
   task automatic test_done;
      $display("mismatches=%0d compares=%0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] x);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, x);
   endtask
   // Stimulus word: watermark, events, tx done, rx done, programmable done
   task automatic ev_case(input logic [7:0] en, input logic [14:0] s, input logic [7:0] x);
      wr_reg(`OFS_CAN_INT_ENABLE, en);
      wr_reg(`OFS_CAN_INT_FLAGS, 8'h00);
      @(posedge clk);
      {wm, ev, txd, rxd, pd} <= s;
      @(posedge clk);
      {wm, ev, txd, rxd, pd} <= 15'h0000;
      rd_chk(`OFS_CAN_INT_FLAGS, x);
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ========
   // Sequence
   initial begin
      seed = 79456;
      n_mismatch = 0;
      compares = 0;
      srst = 1'b1;
      {wr, rd, wm, pend, addr, wdata, ev, txd, rxd, pd, ptx} = 36'h0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      rd_chk(`OFS_CAN_STATUS, 8'h80);
      wr_reg(`OFS_TX_BUFFER_INT_EN, 8'hFF);
      rd_chk(`OFS_TX_BUFFER_INT_EN, 8'h00);
      wr_reg(`OFS_FUNC_MODE, 8'h02);
      wr_reg(`OFS_FUNC_MODE, 8'h03);
      #1 chk({6'h0, fm}, 8'h00);
      for (m = 0; m < 3; m++) begin
         wr_reg(`OFS_FUNC_MODE, m[7:0]);
         #1 chk({6'h0, fm}, m[7:0]);
         for (i = 0; i < 30; i++) begin
            {e, p, f} = 24'($random(seed));
            wr_reg(`OFS_CAN_INT_ENABLE, e);
            wr_reg(`OFS_CAN_INT_PRIORITY, p);
            wr_reg(`OFS_CAN_INT_FLAGS, f);
            rd_chk(`OFS_CAN_INT_ENABLE, e & mask(m[1:0]));
            rd_chk(`OFS_CAN_INT_PRIORITY, p & mask(m[1:0]));
            rd_chk(`OFS_CAN_INT_FLAGS, f & mask(m[1:0]));
            k = {|(e & f & p & mask(m[1:0])), |(e & f & ~p & mask(m[1:0]))};
            chk({6'h0, hi, lo}, {6'h0, k});
            @(posedge clk);
            #1 chk({6'h0, taken}, k[1] ? 8'h02 : {7'h0, k[0]});
         end
         $display("gating test in mode %0d done", m);
      end
      wr_reg(`OFS_TX_BUFFER_INT_EN, 8'hFF);
      rd_chk(`OFS_TX_BUFFER_INT_EN, 8'h1C);
      wr_reg(`OFS_BUFFER_INT_EN, 8'h05);
      rd_chk(`OFS_BUFFER_INT_EN, 8'h05);
      ev_case(8'h00, 15'h0100, 8'h00);
      ev_case(8'h10, 15'h0100, 8'h10);
      ev_case(8'h02, 15'h0001, 8'h02);
      ev_case(8'h02, 15'h0002, 8'h00);
      ev_case(8'h00, 15'h0001, 8'h00);
      ev_case(8'h02, 15'h0040, 8'h02);
      ev_case(8'h00, 15'h7800, 8'hE1);
      ptx <= 6'h01;
      ev_case(8'h10, 15'h0001, 8'h10);
      ev_case(8'h02, 15'h0001, 8'h00);
      $display("buffer event test done");
      // Codes above config are left alone; error recognition is asked elsewhere
      for (m = 0; m < 5; m++) begin
         pend <= 1'b1;
         wr_reg(`OFS_CAN_CONTROL, {m[2:0], 5'h00});
         repeat (3) @(posedge clk);
         #1 chk({5'h0, ms}, 8'(m == 0 ? 4 : m - 1));
         pend <= 1'b0;
         for (i = 0; i < 20 && ms !== m[2:0]; i++) begin
            @(posedge clk);
            #1;
         end
         if (i == 20) n_mismatch++;
         if (i == 20) test_done;
         rd_chk(`OFS_CAN_STATUS, {m[2:0], 5'h00});
      end
      wr_reg(`OFS_CAN_CONTROL, 8'h00);
      rd_chk(`OFS_CAN_STATUS, 8'h00);
      wr_reg(`OFS_FUNC_MODE, 8'h01);
      #1 chk({6'h0, fm}, 8'h02);
      $display("mode handshake test done");
      test_done;
   end
endmodule // tb_can_int_gate
`default_nettype wire
